// ==== rtl/asp_consts.svh ====
// register offsets, field positions, reset values and divider counts of the serial port
// ****************************************************************
// Overview of operation
// - full duplex asynchronous port with the 8-bit and 9-bit variable-rate modes only.
// - one received byte is buffered while the next byte shifts in.
// - writes to the data location load the transmit register only.
// - reads of the data location return the receive buffer, never transmit data.
// - with interrupts enabled, either done flag raises the interrupt request.
// - done flags stay set until software clears them.
// - the baud clock comes from the 8-bit auto-reload timer.
// - transmit uses the timer low counter, receive a hidden copy of it.
// - both counter overflow streams are divided by two to give bit rates.
// - the hidden receive counter runs with the timer and shares its reload value.
// - a start edge on the receive pin forces a reload of the receive counter.
// - timer clock is core clock /4, /12, /48, oscillator /8 or external input.
// - overflow rate is timer clock over 256 minus reload; baud is half.
// - the external oscillator may clock the timer while the core clock runs on.
// - 8-bit frame: start, eight data bits LSB first, stop bit into ninth-bit field.
// - 9-bit frame adds programmable ninth bit; received ninth bit kept, stop ignored.
// - transmit-done flag sets at the start of the stop bit.
// - byte loads only with receive flag clear and, if checked, stop or ninth bit high.
// ****************************************************************
`ifndef ASP_CONSTS_SVH
`define ASP_CONSTS_SVH
`define ASP_OFF_CTRL       8'h00
`define ASP_OFF_DATA       8'h04
`define ASP_OFF_TCTRL      8'h08
`define ASP_OFF_RELOAD     8'h0C
`define ASP_OFF_LOW        8'h10
`define ASP_OFF_IEN        8'h14
`define ASP_CTL_WIDTH      7
`define ASP_CTL_MCE        5
`define ASP_CTL_REN        4
`define ASP_CTL_TX9        3
`define ASP_CTL_RX9        2
`define ASP_CTL_TDONE      1
`define ASP_CTL_RDONE      0
`define ASP_TC_RUN         0
`define ASP_TC_SRC_LSB     1
`define ASP_TC_SRC_MSB     3
`define ASP_RST_RELOAD     8'h00
`define ASP_RST_LOW        8'h00
`define ASP_DIV_A_LAST     2'h3
`define ASP_DIV_B_LAST     2'h2
`define ASP_DIV_C_LAST     2'h3
`define ASP_OSC_LAST       3'h7
`define ASP_CNT_TOP        8'hFF
`define ASP_BITS_LAST      4'h7
`endif

// ==== rtl/asp_pkg.sv ====
// shared types of the serial port
package asp_pkg;
	typedef enum logic [2:0] {CS_DIV4, CS_DIV12, CS_DIV48, CS_OSC8, CS_EXT} asp_clk_src_t;
	typedef enum logic [2:0] {TX_IDLE, TX_DATA, TX_NINTH, TX_END, TX_STOP} asp_tx_state_t;
	typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_NINTH, RX_STOP} asp_rx_state_t;
endpackage

// ==== rtl/asp_sync.sv ====
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module asp_sync #(
	parameter int W = 1
) (
	input  wire logic         clk_in,
	input  wire logic         rst_n_in,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);
	import asp_pkg::*;
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] q;
	} asp_sync_st_t;
	asp_sync_st_t st_ff;
	asp_sync_st_t nxt_st;

	always_comb begin
		nxt_st    = st_ff;
		nxt_st.s1 = async_in;
		nxt_st.s2 = st_ff.s1;
		nxt_st.s3 = st_ff.s2;
		// a change only counts once the second and third stage agree
		for (int i = 0; i < W; i++) begin
			if (st_ff.s2[i] == st_ff.s3[i]) begin
				nxt_st.q[i] = st_ff.s3[i];
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			st_ff <= '1;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign sync_out = st_ff.q;
endmodule

// ==== rtl/asp_baud_timer.sv ====
// baud timer: prescaler, 8-bit auto-reload counter and its hidden receive copy
`timescale 1ns/1ps
`include "asp_consts.svh"
module asp_baud_timer (
	input  wire logic                  clk_in,
	input  wire logic                  rst_n_in,
	input  wire logic                  run_in,
	input  wire asp_pkg::asp_clk_src_t src_in,
	input  wire logic [7:0]            reload_in,
	input  wire logic                  low_wr_in,
	input  wire logic [7:0]            low_wdata_in,
	input  wire logic                  osc_in,
	input  wire logic                  ext_in,
	input  wire logic                  rx_restart_in,
	output logic      [7:0]            low_out,
	output logic                       tx_tick_out,
	output logic                       rx_tick_out
);
	import asp_pkg::*;
	typedef struct packed {
		logic [1:0] pre_a;
		logic [1:0] pre_b;
		logic [1:0] pre_c;
		logic [2:0] osc_cnt;
		logic       osc_prev;
		logic       ext_prev;
		logic [7:0] tx_cnt;
		logic [7:0] rx_cnt;
		logic       tx_div;
		logic       rx_div;
	} asp_tmr_st_t;
	asp_tmr_st_t st_ff;
	asp_tmr_st_t nxt_st;
	logic        tick4;
	logic        tick12;
	logic        tick_osc;
	logic        tmr_tick;
	logic        tx_ovf;
	logic        rx_ovf;

	always_comb begin
		nxt_st   = st_ff;
		tick4    = st_ff.pre_a == `ASP_DIV_A_LAST;
		tick12   = tick4 && st_ff.pre_b == `ASP_DIV_B_LAST;
		tick_osc = osc_in && !st_ff.osc_prev && st_ff.osc_cnt == `ASP_OSC_LAST;
		unique case (src_in)
			CS_DIV4:  tmr_tick = tick4;
			CS_DIV12: tmr_tick = tick12;
			CS_DIV48: tmr_tick = tick12 && st_ff.pre_c == `ASP_DIV_C_LAST;
			CS_OSC8:  tmr_tick = tick_osc;
			CS_EXT:   tmr_tick = !ext_in && st_ff.ext_prev;
			default:  tmr_tick = 1'b0;
		endcase
		tx_ovf = run_in && tmr_tick && st_ff.tx_cnt == `ASP_CNT_TOP;
		rx_ovf = run_in && tmr_tick && st_ff.rx_cnt == `ASP_CNT_TOP;
		nxt_st.pre_a    = st_ff.pre_a + 2'h1;
		if (tick4) begin
			nxt_st.pre_b = tick12 ? 2'h0 : st_ff.pre_b + 2'h1;
		end
		if (tick12) begin
			nxt_st.pre_c = st_ff.pre_c + 2'h1;
		end
		nxt_st.osc_prev = osc_in;
		nxt_st.ext_prev = ext_in;
		if (osc_in && !st_ff.osc_prev) begin
			nxt_st.osc_cnt = st_ff.osc_cnt + 3'h1;
		end
		if (low_wr_in) begin
			nxt_st.tx_cnt = low_wdata_in;
		end else if (run_in && tmr_tick) begin
			nxt_st.tx_cnt = tx_ovf ? reload_in : st_ff.tx_cnt + 8'h01;
		end
		nxt_st.tx_div = st_ff.tx_div ^ tx_ovf;
		// start edge realigns only the receive copy, transmit keeps its phase
		if (rx_restart_in) begin
			nxt_st.rx_cnt = reload_in;
			nxt_st.rx_div = 1'b0;
		end else begin
			if (run_in && tmr_tick) begin
				nxt_st.rx_cnt = rx_ovf ? reload_in : st_ff.rx_cnt + 8'h01;
			end
			nxt_st.rx_div = st_ff.rx_div ^ rx_ovf;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			st_ff <= '0;
			// same level as the synchroniser's reset, so no false edge follows reset
			st_ff.osc_prev <= 1'b1;
			st_ff.ext_prev <= 1'b1;
			st_ff.tx_cnt <= `ASP_RST_LOW;
			st_ff.rx_cnt <= `ASP_RST_LOW;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign low_out     = st_ff.tx_cnt;
	// second overflow ends a bit; receive samples on the first, i.e. mid-bit
	assign tx_tick_out = tx_ovf && st_ff.tx_div;
	assign rx_tick_out = rx_ovf && !st_ff.rx_div;

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);

	a_tx_reload_value: assert property (
		tx_ovf && !low_wr_in |=> st_ff.tx_cnt == $past(reload_in)
	) else $error("transmit counter did not reload");
	a_rx_start_align: assert property (
		rx_restart_in |=> st_ff.rx_cnt == $past(reload_in) && !st_ff.rx_div
	) else $error("receive counter not realigned on start edge");
	a_rx_stopped_idle: assert property (
		!run_in && !rx_restart_in |=> $stable(st_ff.rx_cnt)
	) else $error("receive counter ran with timer stopped");
	a_tx_half_rate: assert property (
		tx_tick_out |=> !st_ff.tx_div && !tx_tick_out
	) else $error("transmit overflow not divided by two");
endmodule

// ==== rtl/asp_serial_port.sv ====
// serial port core with baud timer and AHB-Lite register slave
//
// The implementer's own choices: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps
`include "asp_consts.svh"
module asp_serial_port (
	input  wire logic        CLK_SYS_IN,
	input  wire logic        RST_N_IN,
	input  wire logic        HSEL_IN,
	input  wire logic [31:0] HADDR_IN,
	input  wire logic [1:0]  HTRANS_IN,
	input  wire logic        HWRITE_IN,
	input  wire logic [2:0]  HSIZE_IN,
	input  wire logic [31:0] HWDATA_IN,
	input  wire logic        HREADY_IN,
	output logic      [31:0] HRDATA_OUT,
	output logic             HREADYOUT_OUT,
	output logic             HRESP_OUT,
	input  wire logic        RXD_IN,
	output logic             TXD_OUT,
	input  wire logic        TIMER_EXT_IN,
	input  wire logic        EXT_OSC_IN,
	output logic             IRQ_OUT
);
	import asp_pkg::*;

	// ****************************************************************
	// state
	// ****************************************************************
	typedef struct packed {
		logic          ph_valid;
		logic          ph_write;
		logic [7:0]    ph_addr;
		logic [31:0]   rdata;
		logic          frame_width_select;
		logic          multiproc_check_enable;
		logic          rx_enable;
		logic          tx_ninth_bit;
		logic          rx_ninth_bit;
		logic          transmit_done_flag;
		logic          receive_done_flag;
		logic          run;
		asp_clk_src_t  src;
		logic [7:0]    timer_reload_value;
		logic          ien;
		logic          irq;
		asp_tx_state_t tx_state;
		logic          tx_go;
		logic [7:0]    tx_data;
		logic [8:0]    tx_shift;
		logic [3:0]    tx_cnt;
		logic          txd;
		asp_rx_state_t rx_state;
		logic [7:0]    rx_shift;
		logic [3:0]    rx_cnt;
		logic [7:0]    rx_buf;
		logic          rx_bit9;
		logic          rx_prev;
	} asp_core_st_t;

	asp_core_st_t st_ff;
	asp_core_st_t nxt_st;
	logic         rx_q;
	logic         ext_q;
	logic         osc_q;
	logic [7:0]   low_cnt;
	logic         tx_tick;
	logic         rx_tick;
	logic         addr_take;
	logic         wr_now;
	logic         wr_ctrl;
	logic         wr_data;
	logic         wr_tctrl;
	logic         wr_reload;
	logic         wr_low;
	logic         wr_ien;
	logic [7:0]   wd;
	logic         rx_fall;
	logic         rx_chk;
	logic         rx_accept;

	// ****************************************************************
	// decode helpers
	// ****************************************************************
	function automatic logic asp_hit(input logic [31:0] a, input logic [2:0] sz);
		// only aligned whole words inside the block are mapped
		asp_hit = a[31:8] == 24'h0 && a[1:0] == 2'h0 && sz == 3'h2 && a[7:0] <= `ASP_OFF_IEN;
	endfunction

	function automatic logic [31:0] asp_read(input logic [7:0] a, input asp_core_st_t s,
		input logic [7:0] low);
		asp_read = 32'h0;
		unique case (a)
			`ASP_OFF_CTRL:   asp_read[7:0] = {s.frame_width_select, 1'b1,
				s.multiproc_check_enable, s.rx_enable, s.tx_ninth_bit, s.rx_ninth_bit,
				s.transmit_done_flag, s.receive_done_flag};
			`ASP_OFF_DATA:   asp_read[7:0] = s.rx_buf;
			`ASP_OFF_TCTRL:  asp_read[3:0] = {s.src, s.run};
			`ASP_OFF_RELOAD: asp_read[7:0] = s.timer_reload_value;
			`ASP_OFF_LOW:    asp_read[7:0] = low;
			`ASP_OFF_IEN:    asp_read[0]   = s.ien;
			default:         asp_read      = 32'h0;
		endcase
	endfunction

	// ****************************************************************
	// pins and baud timer
	// ****************************************************************
	asp_sync #(
		.W (3)
	) u_sync (
		.clk_in   (CLK_SYS_IN),
		.rst_n_in (RST_N_IN),
		.async_in ({EXT_OSC_IN, TIMER_EXT_IN, RXD_IN}),
		.sync_out ({osc_q, ext_q, rx_q})
	);

	asp_baud_timer u_timer (
		.clk_in        (CLK_SYS_IN),
		.rst_n_in      (RST_N_IN),
		.run_in        (st_ff.run),
		.src_in        (st_ff.src),
		.reload_in     (st_ff.timer_reload_value),
		.low_wr_in     (wr_low),
		.low_wdata_in  (wd),
		.osc_in        (osc_q),
		.ext_in        (ext_q),
		.rx_restart_in (rx_fall),
		.low_out       (low_cnt),
		.tx_tick_out   (tx_tick),
		.rx_tick_out   (rx_tick)
	);

	// ****************************************************************
	// bus decode
	// ****************************************************************
	assign addr_take = HSEL_IN && HREADY_IN && HTRANS_IN[1];
	assign wr_now    = st_ff.ph_valid && st_ff.ph_write;
	assign wr_ctrl   = wr_now && st_ff.ph_addr == `ASP_OFF_CTRL;
	assign wr_data   = wr_now && st_ff.ph_addr == `ASP_OFF_DATA;
	assign wr_tctrl  = wr_now && st_ff.ph_addr == `ASP_OFF_TCTRL;
	assign wr_reload = wr_now && st_ff.ph_addr == `ASP_OFF_RELOAD;
	assign wr_low    = wr_now && st_ff.ph_addr == `ASP_OFF_LOW;
	assign wr_ien    = wr_now && st_ff.ph_addr == `ASP_OFF_IEN;
	assign wd        = HWDATA_IN[7:0];

	// start edge only arms while idle, so data falling edges never realign
	assign rx_fall   = st_ff.rx_enable && st_ff.rx_state == RX_IDLE && st_ff.rx_prev && !rx_q;
	assign rx_chk    = st_ff.frame_width_select ? st_ff.rx_bit9 : rx_q;
	assign rx_accept = !st_ff.receive_done_flag && (!st_ff.multiproc_check_enable || rx_chk);

	// ****************************************************************
	// next state
	// ****************************************************************
	always_comb begin
		nxt_st = st_ff;
		if (wr_ctrl) begin
			nxt_st.frame_width_select     = wd[`ASP_CTL_WIDTH];
			nxt_st.multiproc_check_enable = wd[`ASP_CTL_MCE];
			nxt_st.rx_enable              = wd[`ASP_CTL_REN];
			nxt_st.tx_ninth_bit           = wd[`ASP_CTL_TX9];
			nxt_st.rx_ninth_bit           = wd[`ASP_CTL_RX9];
			nxt_st.transmit_done_flag     = wd[`ASP_CTL_TDONE];
			nxt_st.receive_done_flag      = wd[`ASP_CTL_RDONE];
		end
		if (wr_tctrl) begin
			nxt_st.run = wd[`ASP_TC_RUN];
			nxt_st.src = asp_clk_src_t'(wd[`ASP_TC_SRC_MSB:`ASP_TC_SRC_LSB]);
		end
		if (wr_reload) begin
			nxt_st.timer_reload_value = wd;
		end
		if (wr_ien) begin
			nxt_st.ien = wd[0];
		end

		// transmitter: flag sets below the software write, so a set wins
		if (tx_tick) begin
			unique case (st_ff.tx_state)
				TX_IDLE, TX_STOP: begin
					nxt_st.txd      = 1'b1;
					nxt_st.tx_state = TX_IDLE;
					if (st_ff.tx_go) begin
						nxt_st.txd      = 1'b0;
						nxt_st.tx_shift = {st_ff.tx_ninth_bit, st_ff.tx_data};
						nxt_st.tx_cnt   = 4'h0;
						nxt_st.tx_go    = 1'b0;
						nxt_st.tx_state = TX_DATA;
					end
				end
				TX_DATA: begin
					nxt_st.txd      = st_ff.tx_shift[0];
					nxt_st.tx_shift = st_ff.tx_shift >> 1;
					nxt_st.tx_cnt   = st_ff.tx_cnt + 4'h1;
					if (st_ff.tx_cnt == `ASP_BITS_LAST) begin
						nxt_st.tx_state = st_ff.frame_width_select ? TX_NINTH : TX_END;
					end
				end
				TX_NINTH: begin
					nxt_st.txd      = st_ff.tx_shift[0];
					nxt_st.tx_state = TX_END;
				end
				TX_END: begin
					nxt_st.txd                = 1'b1;
					nxt_st.transmit_done_flag = 1'b1;
					nxt_st.tx_state           = TX_STOP;
				end
				default: begin
					nxt_st.tx_state = TX_IDLE;
				end
			endcase
		end

		// receiver: samples land mid-bit because the start edge reloads the timer
		nxt_st.rx_prev = rx_q;
		if (rx_fall) begin
			nxt_st.rx_state = RX_START;
		end else if (rx_tick) begin
			unique case (st_ff.rx_state)
				RX_IDLE: begin
					nxt_st.rx_state = RX_IDLE;
				end
				RX_START: begin
					// a glitch shorter than half a bit is dropped here
					nxt_st.rx_cnt   = 4'h0;
					nxt_st.rx_state = rx_q ? RX_IDLE : RX_DATA;
				end
				RX_DATA: begin
					nxt_st.rx_shift = {rx_q, st_ff.rx_shift[7:1]};
					nxt_st.rx_cnt   = st_ff.rx_cnt + 4'h1;
					if (st_ff.rx_cnt == `ASP_BITS_LAST) begin
						nxt_st.rx_state = st_ff.frame_width_select ? RX_NINTH : RX_STOP;
					end
				end
				RX_NINTH: begin
					nxt_st.rx_bit9  = rx_q;
					nxt_st.rx_state = RX_STOP;
				end
				RX_STOP: begin
					// back to idle mid-stop so the next start edge is not missed
					nxt_st.rx_state = RX_IDLE;
					if (rx_accept) begin
						nxt_st.rx_buf            = st_ff.rx_shift;
						nxt_st.rx_ninth_bit      = rx_chk;
						nxt_st.receive_done_flag = 1'b1;
					end
				end
				default: begin
					nxt_st.rx_state = RX_IDLE;
				end
			endcase
		end

		// a data write queues a byte; taken at the next bit tick once idle
		if (wr_data) begin
			nxt_st.tx_data = wd;
			nxt_st.tx_go   = 1'b1;
		end

		nxt_st.irq = st_ff.ien && (st_ff.transmit_done_flag || st_ff.receive_done_flag);

		nxt_st.ph_valid = addr_take && asp_hit(HADDR_IN, HSIZE_IN);
		nxt_st.ph_write = HWRITE_IN;
		nxt_st.ph_addr  = HADDR_IN[7:0];
		nxt_st.rdata    = 32'h0;
		if (nxt_st.ph_valid && !HWRITE_IN) begin
			// taken from the next state so a read right behind a write sees it, except at the low counter, which reads the current count
			nxt_st.rdata = asp_read(HADDR_IN[7:0], nxt_st, low_cnt);
		end
	end

	always_ff @(posedge CLK_SYS_IN) begin
		if (!RST_N_IN) begin
			st_ff                    <= '0;
			st_ff.timer_reload_value <= `ASP_RST_RELOAD;
			st_ff.txd                <= 1'b1;
			st_ff.rx_prev            <= 1'b1;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ****************************************************************
	// outputs
	// ****************************************************************
	assign HRDATA_OUT    = st_ff.rdata;
	assign HREADYOUT_OUT = 1'b1;
	assign HRESP_OUT     = 1'b0;
	assign TXD_OUT       = st_ff.txd;
	assign IRQ_OUT       = st_ff.irq;

	// ****************************************************************
	// checks
	// ****************************************************************
	default clocking cb @(posedge CLK_SYS_IN); endclocking
	default disable iff (!RST_N_IN);

	a_tx_done_stop: assert property (
		tx_tick && st_ff.tx_state == TX_END
		|=> st_ff.transmit_done_flag && TXD_OUT && st_ff.tx_state == TX_STOP
	) else $error("transmit-done flag not set at stop bit");

	a_tx_start_bit: assert property (
		tx_tick && st_ff.tx_state == TX_IDLE && st_ff.tx_go
		|=> !TXD_OUT && st_ff.tx_shift[7:0] == $past(st_ff.tx_data)
	) else $error("start bit or transmit byte wrong");

	a_data_write: assert property (
		wr_data |=> st_ff.tx_data == $past(HWDATA_IN[7:0]) && st_ff.tx_go
	) else $error("data write did not load transmit register");

	a_rx_untouched: assert property (
		wr_data && !(rx_tick && st_ff.rx_state == RX_STOP) |=> $stable(st_ff.rx_buf)
	) else $error("data write changed receive buffer");

	a_data_read: assert property (
		addr_take && HADDR_IN == {24'h0, `ASP_OFF_DATA} && HSIZE_IN == 3'h2 && !HWRITE_IN
		|=> HRDATA_OUT == {24'h0, st_ff.rx_buf}
	) else $error("data read did not return receive buffer");

	a_irq_request: assert property (
		st_ff.ien && (st_ff.transmit_done_flag || st_ff.receive_done_flag) ##1 1'b1
		|-> IRQ_OUT
	) else $error("interrupt not requested for a set flag");

	a_flag_sticky: assert property (
		!wr_ctrl |=> st_ff.transmit_done_flag >= $past(st_ff.transmit_done_flag)
			&& st_ff.receive_done_flag >= $past(st_ff.receive_done_flag)
	) else $error("done flag cleared without software");

	a_rx_gate: assert property (
		st_ff.receive_done_flag && !wr_ctrl |=> $stable(st_ff.rx_buf) && $stable(st_ff.rx_ninth_bit)
	) else $error("receive buffer loaded while flag set");

	a_rx_mce_drop: assert property (
		rx_tick && !rx_fall && st_ff.rx_state == RX_STOP && st_ff.multiproc_check_enable
		&& !rx_chk && !wr_ctrl |=> $stable(st_ff.receive_done_flag) && $stable(st_ff.rx_buf)
	) else $error("byte accepted despite multiprocessor check");

	a_rx_realign: assert property (
		rx_fall |=> st_ff.rx_state == RX_START
	) else $error("start edge not taken");
endmodule

// ==== test/asp_remote_uart.sv ====
// remote serial transceiver model facing the port's serial pins
`timescale 1ns/1ps
module asp_remote_uart (
	input  wire logic clk_in,
	input  wire logic line_in,
	output logic      line_out,
	input  wire logic nine_in
);
	int         bit_cyc = 32;
	int         rx_cnt  = 0;
	logic [8:0] rx_word = 9'h000;

	// ****
	// sender: line idles high, as with a pull-up
	// ****
	initial line_out = 1'b1;

	task automatic send(input logic [8:0] w, input logic stop);
		line_out <= 1'b0;
		repeat (bit_cyc) @(posedge clk_in);
		for (int k = 0; k < (nine_in ? 9 : 8); k++) begin
			line_out <= w[k];
			repeat (bit_cyc) @(posedge clk_in);
		end
		line_out <= stop;
		repeat (bit_cyc) @(posedge clk_in);
		line_out <= 1'b1;
	endtask

	// ****
	// receiver: samples mid-bit, counts frames at mid-stop
	// ****
	always begin
		@(negedge line_in);
		repeat (bit_cyc / 2) @(posedge clk_in);
		for (int k = 0; k < (nine_in ? 9 : 8); k++) begin
			repeat (bit_cyc) @(posedge clk_in);
			rx_word[k] = line_in;
		end
		repeat (bit_cyc) @(posedge clk_in);
		rx_cnt++;
	end
endmodule

// ==== test/tb.sv ====
// testbench: bus tasks driving the serial port against the remote transceiver
`timescale 1ns/1ps
module tb;
	logic        clk, rst_n, hsel, hwrite, nine, ext_osc, timer_ext;
	logic [2:0]  pin_div = 3'h0;
	logic [1:0]  htrans;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic        hready, hresp, txd, rxd, irq;
	int          err_count, checks_done, i;
	int          cyc [5] = '{16, 48, 192, 128, 32};

	asp_serial_port uut (
		.CLK_SYS_IN   (clk),
		.RST_N_IN     (rst_n),
		.HSEL_IN      (hsel),
		.HADDR_IN     (haddr),
		.HTRANS_IN    (htrans),
		.HWRITE_IN    (hwrite),
		.HSIZE_IN     (3'h2),
		.HWDATA_IN    (hwdata),
		.HREADY_IN    (hready),
		.HRDATA_OUT   (hrdata),
		.HREADYOUT_OUT(hready),
		.HRESP_OUT    (hresp),
		.RXD_IN       (rxd),
		.TXD_OUT      (txd),
		.TIMER_EXT_IN (timer_ext),
		.EXT_OSC_IN   (ext_osc),
		.IRQ_OUT      (irq)
	);
	asp_remote_uart rem (
		.clk_in  (clk),
		.line_in (txd),
		.line_out(rxd),
		.nine_in (nine)
	);

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// oscillator pin: period of four core cycles, the shortest the agreement filter passes;
	// timer input pin: period of eight, so its bit time differs from the /4 source
	always @(posedge clk) begin
		pin_div   <= pin_div + 3'h1;
		ext_osc   <= pin_div[1];
		timer_ext <= pin_div[2];
	end

	// ****
	// bus and check tasks
	// ****
	task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] wd);
		@(posedge clk);
		haddr  <= a;
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge clk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge clk); while (hready !== 1'b1);
		rd = hrdata;
	endtask

	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		checks_done++;
		if (s !== e) begin
			err_count++;
			$display("CHECK FAILED %s exp %h got %h", n, e, s);
		end
	endtask

	task automatic rdchk(input string n, input logic [31:0] a, input logic [31:0] e);
		bus(a, 1'b0, 32'h0);
		chk(n, rd, e);
	endtask

	task automatic finish_test;
		if (err_count == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	initial begin
		#3000000;
		err_count++;
		finish_test;
	end

	// ****
	// scenarios
	// ****
	initial begin
		rst_n = 1'b0;
		hsel = 1'b1;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hwdata = 32'h0;
		nine = 1'b0;
		err_count = 0;
		checks_done = 0;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		rdchk("ctrl reset", 32'h00, 32'h40);
		rdchk("unmapped", 32'h20, 32'h0);
		chk("hresp okay", {31'h0, hresp}, 32'h0);
		chk("txd idle", {31'h0, txd}, 32'h1);
		bus(32'h10, 1'b1, 32'h33);
		rdchk("low counter", 32'h10, 32'h33);
		bus(32'h14, 1'b1, 32'h1);
		// each source gives its own bit time; a wrong divider garbles the byte
		for (i = 0; i < 5; i++) begin
			bus(32'h08, 1'b1, (i << 1) | 1);
			bus(32'h0C, 1'b1, 32'hFE);
			rem.bit_cyc = cyc[i];
			bus(32'h04, 1'b1, 32'hA0 + i);
			wait (rem.rx_cnt == i + 1);
			chk("tx byte", {24'h0, rem.rx_word[7:0]}, 32'hA0 + i);
			rdchk("tx done", 32'h00, 32'h42);
			chk("irq set", {31'h0, irq}, 32'h1);
			rdchk("data read", 32'h04, 32'h0);
			bus(32'h00, 1'b1, 32'h0);
			repeat (2) @(posedge clk);
			chk("irq clear", {31'h0, irq}, 32'h0);
		end
		bus(32'h08, 1'b1, 32'h1);
		bus(32'h0C, 1'b1, 32'hFC);
		rem.bit_cyc = 32;
		bus(32'h00, 1'b1, 32'h10);
		rem.send(9'h03C, 1'b1);
		repeat (8) @(posedge clk);
		rdchk("rx flags", 32'h00, 32'h55);
		rem.send(9'h0C3, 1'b1);
		repeat (8) @(posedge clk);
		rdchk("rx kept", 32'h04, 32'h3C);
		bus(32'h00, 1'b1, 32'h30);
		rem.send(9'h066, 1'b0);
		repeat (8) @(posedge clk);
		rdchk("bad stop", 32'h00, 32'h70);
		nine = 1'b1;
		bus(32'h00, 1'b1, 32'hB8);
		fork
			bus(32'h04, 1'b1, 32'h5A);
			rem.send(9'h181, 1'b1);
		join
		wait (rem.rx_cnt == 6);
		repeat (8) @(posedge clk);
		chk("tx ninth", {23'h0, rem.rx_word}, 32'h15A);
		rdchk("duplex flags", 32'h00, 32'hFF);
		rdchk("rx nine data", 32'h04, 32'h81);
		finish_test;
	end
endmodule
